// *** verif/test_touch_matrix_scan_sequencer.sv ***
`timescale 1ns/10ps
module test_touch_matrix_scan_sequencer;
  import touch_scan_pkg::*;
  // ==========================================================
  // Signals
  logic                      core_clk, sys_rst, scan_en;
  logic [NUM_KEYS*BL_W-1:0]  burst_len, bl_v;
  logic [NUM_KEYS*DIL_W-1:0] det_lim, dil_v;
  logic [NUM_LINES-1:0]      x_drive, y_capture, y_cmp, x_prev;
  logic                      cs_reset, adc_ramp, res_valid, scan_done;
  logic [KEY_W-1:0]          res_key;
  logic [CNT_W-1:0]          res_data;
  logic [LINE_W-1:0]         active_line;
  logic [BL_W-1:0]           cap_cnt [NUM_LINES];
  logic [BL_W-1:0]           cap_snap [NUM_LINES];
  logic                      slot_new;
  int                        n_mismatch, check_count, n_pulse;
  logic [KEY_W-1:0]          key_q[$];
  logic [CNT_W-1:0]          dat_q[$];
  logic [LINE_W-1:0]         line_q[$];

  touch_matrix_scan_sequencer u_dut (
    .CORE_CLK_I(core_clk), .SYS_RST_I(sys_rst), .SCAN_EN_I(scan_en),
    .BURST_LEN_I(burst_len), .DET_INT_LIMIT_I(det_lim),
    .X_DRIVE_O(x_drive), .Y_CAPTURE_O(y_capture), .CS_RESET_O(cs_reset),
    .ADC_RAMP_O(adc_ramp), .Y_CMP_I(y_cmp), .RES_VALID_O(res_valid),
    .RES_KEY_O(res_key), .RES_DATA_O(res_data), .SCAN_DONE_O(scan_done),
    .ACTIVE_LINE_O(active_line));

  touch_matrix_model u_matrix (
    .clk_i(core_clk), .rst_i(sys_rst), .x_drive_i(x_drive),
    .y_capture_i(y_capture), .cs_reset_i(cs_reset), .adc_ramp_i(adc_ramp),
    .y_cmp_o(y_cmp), .cap_cnt_o(cap_cnt));

  // ==========================================================
  // Checking and monitor
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (res_valid === 1'b1) begin
      key_q.push_back(res_key);
      dat_q.push_back(res_data);
    end
    if (cs_reset === 1'b1) slot_new = 1'b1;
    // Counts clear at the next slot's cap reset, so keep them here
    if (adc_ramp === 1'b1) cap_snap = cap_cnt;
    if (x_drive !== '0) begin
      check("x_drive", 16'(x_drive), 16'(8'h01 << active_line));
      if (x_prev === '0) begin
        n_pulse++;
        if (slot_new) line_q.push_back(active_line);
        slot_new = 1'b0;
      end
    end
    x_prev = x_drive;
  end

  // ==========================================================
  // Stimulus helpers
  task automatic set_key(input int k, input logic [7:0] bl,
                         input logic [7:0] dil);
    bl_v[k*8+:8]  = bl;
    dil_v[k*8+:8] = dil;
  endtask

  task automatic run_pass(input int passes);
    int dn;
    dn = 0;
    @(posedge core_clk);
    sys_rst   <= 1'b1;
    scan_en   <= 1'b0;
    burst_len <= bl_v;
    det_lim   <= dil_v;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    key_q.delete();
    dat_q.delete();
    line_q.delete();
    n_pulse  = 0;
    slot_new = 1'b0;
    @(posedge core_clk);
    scan_en <= 1'b1;
    for (int i = 0; i < 30000 && dn < passes; i++) begin
      @(posedge core_clk);
      if (scan_done === 1'b1) dn++;
    end
    if (dn < passes) begin
      n_mismatch++;
      $display("mismatch scan_done expected %0d seen %0d", passes, dn);
      stop_test();
    end
    repeat (3) @(posedge core_clk);
  endtask

  task automatic check_seq(input int ek[$], input int el[$]);
    check("res_count", 16'(key_q.size()), 16'(ek.size()));
    check("slot_count", 16'(line_q.size()), 16'(el.size()));
    foreach (ek[i]) begin
      if (i < key_q.size()) begin
        check("res_key", 16'(key_q[i]), 16'(ek[i]));
      end
    end
    foreach (el[i]) begin
      if (i < line_q.size()) begin
        check("line", 16'(line_q[i]), 16'(el[i]));
      end
    end
    // Host side: every reported result must be a real conversion
    foreach (dat_q[i]) begin
      check("res_data_ok", 16'(dat_q[i] != NO_TRIP_VAL), 16'd1);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic scen_order;
    bl_v  = '0;
    dil_v = '0;
    set_key(1, 8'h02, 8'h01);
    set_key(41, 8'h02, 8'hff);
    set_key(19, 8'h02, 8'h10);
    set_key(27, 8'h02, 8'h00);
    set_key(62, 8'h02, 8'h02);
    run_pass(2);
    check_seq('{1, 41, 19, 62, 1, 41, 19, 62}, '{1, 3, 6, 1, 3, 6});
  endtask

  task automatic scen_burst;
    bl_v  = '0;
    dil_v = '0;
    set_key(0, 8'h01, 8'h04);
    set_key(8, 8'h03, 8'h04);
    set_key(16, 8'h05, 8'h04);
    set_key(24, 8'h07, 8'h00);
    run_pass(1);
    check_seq('{0, 8, 16}, '{0});
    check("pulses", 16'(n_pulse), 16'd5);
    check("cap0", 16'(cap_snap[0]), 16'd1);
    check("cap1", 16'(cap_snap[1]), 16'd3);
    check("cap2", 16'(cap_snap[2]), 16'd5);
    check("cap3", 16'(cap_snap[3]), 16'd0);
    if (dat_q.size() == 3) begin
      check("data_trip", 16'(dat_q[0] != NO_TRIP_VAL), 16'd1);
      check("data_ord1", 16'(dat_q[1] > dat_q[0]), 16'd1);
      check("data_ord2", 16'(dat_q[2] > dat_q[1]), 16'd1);
    end
  endtask

  task automatic scen_last;
    bl_v  = '0;
    dil_v = '0;
    set_key(63, 8'h04, 8'h01);
    run_pass(2);
    check_seq('{63, 63}, '{7, 7});
    check("pulses", 16'(n_pulse), 16'd8);
  endtask

  task automatic scen_none;
    bl_v  = '0;
    dil_v = '0;
    set_key(5, 8'h03, 8'h00);
    // Fresh start: dropping keys inside a live slot is not this case
    run_pass(0);
    repeat (400) @(posedge core_clk);
    check("idle_pulses", 16'(n_pulse), 16'd0);
    check("idle_results", 16'(key_q.size()), 16'd0);
  endtask

  // ==========================================================
  // Clock and main sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    sys_rst     = 1'b1;
    scan_en     = 1'b0;
    burst_len   = '0;
    det_lim     = '0;
    bl_v        = '0;
    dil_v       = '0;
    x_prev      = '0;
    slot_new    = 1'b0;
    n_mismatch  = 0;
    check_count = 0;
    n_pulse     = 0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    scen_order();
    scen_burst();
    scen_last();
    scen_none();
    stop_test();
  end
endmodule // test_touch_matrix_scan_sequencer

// *** verif/touch_matrix_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// Electrode matrix with sample caps and single-slope comparators
module touch_matrix_model
  import touch_scan_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Device pins
  input  wire logic [NUM_LINES-1:0] x_drive_i,
  input  wire logic [NUM_LINES-1:0] y_capture_i,
  input  wire logic                 cs_reset_i,
  input  wire logic                 adc_ramp_i,
  output logic      [NUM_LINES-1:0] y_cmp_o,
  // Observation
  output logic      [BL_W-1:0]      cap_cnt_o [NUM_LINES]
);
  logic [NUM_LINES-1:0] x_prev_r;
  logic [CNT_W-1:0]     ramp_r;

  // More captured charge means a later trip, so longer bursts read higher
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      x_prev_r <= '0;
      ramp_r   <= '0;
      y_cmp_o  <= '0;
      for (int y = 0; y < NUM_LINES; y++) begin
        cap_cnt_o[y] <= '0;
      end
    end else begin
      x_prev_r <= x_drive_i;
      ramp_r   <= adc_ramp_i ? ramp_r + 12'h001 : 12'h000;
      for (int y = 0; y < NUM_LINES; y++) begin
        if (cs_reset_i) begin
          cap_cnt_o[y] <= '0;
        end else if (x_drive_i != '0 && x_prev_r == '0 && y_capture_i[y]) begin
          cap_cnt_o[y] <= cap_cnt_o[y] + 8'h01;
        end
        y_cmp_o[y] <= adc_ramp_i &&
                      (ramp_r >= 12'h010 + {cap_cnt_o[y], 3'h0});
      end
    end
  end
endmodule // touch_matrix_model

// *** verilog/rx_channel.sv ***
`timescale 1ns/10ps
module rx_channel
  import touch_scan_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Sequencer control
  input  wire logic             clr_i,
  input  wire logic             en_i,
  input  wire logic             win_i,
  input  wire logic [BL_W-1:0]  pulse_i,
  input  wire logic [BL_W-1:0]  burst_len_i,
  input  wire logic             conv_i,
  input  wire logic [CNT_W-1:0] time_i,
  // Synchronised comparator
  input  wire logic             cmp_i,
  // Outputs
  output logic                  cap_o,
  output logic [CNT_W-1:0]      val_o,
  output logic                  done_o
);

  logic             done_r;
  logic             done_nxt;
  logic [CNT_W-1:0] val_r;
  logic [CNT_W-1:0] val_nxt;

  // Line pulsed by all, charge kept only for this key's own count
  assign cap_o = win_i & en_i & (pulse_i < burst_len_i);

  // ==========================================================
  // Single-slope conversion latch
  always_comb begin
    done_nxt = done_r;
    val_nxt  = val_r;
    if (clr_i) begin
      done_nxt = 1'b0;
      val_nxt  = NO_TRIP_VAL;
    end else if (conv_i && en_i && cmp_i && !done_r) begin
      done_nxt = 1'b1;
      val_nxt  = time_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_r <= 1'b0;
      val_r  <= NO_TRIP_VAL;
    end else begin
      done_r <= done_nxt;
      val_r  <= val_nxt;
    end
  end

  assign val_o  = val_r;
  assign done_o = done_r;

  // ==========================================================
  // Checks
  AST_CAP_LIMIT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cap_o |-> (en_i && win_i && (pulse_i < burst_len_i)))
    else $error("capture outside key burst length");

  AST_VAL_HOLD: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (done_r && !clr_i) |=> (done_r && $stable(val_r)))
    else $error("converted value changed before clear");

endmodule // rx_channel

// *** verilog/touch_matrix_scan_sequencer.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - Key index is receive line times eight plus drive line.
// - A fresh scan starts at the lowest drive line with an enabled key, receive line zero.
// - Drive lines go in ascending order; receive lines ascend within.
// - All keys on a drive line share one burst of pulses.
// - Burst on one drive line ends before the next line is excited.
// - After each burst every enabled receive line is converted, then reported.
// - Each receive line captures only for its key's burst length.
// - Disabled keys are left out of acquisition and results.
// - Drive lines with no enabled key get no timeslot at all.
// - Detect integrator limit zero means disabled, nonzero enabled.
// - Per-line slot time does not depend on how many lines are skipped.
module touch_matrix_scan_sequencer
  import touch_scan_pkg::*;
(
  // Clock and reset
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        SYS_RST_I,
  // Configuration, same clock domain
  input  wire logic                        SCAN_EN_I,
  input  wire logic [NUM_KEYS*BL_W-1:0]    BURST_LEN_I,
  input  wire logic [NUM_KEYS*DIL_W-1:0]   DET_INT_LIMIT_I,
  // Matrix side
  output logic      [NUM_LINES-1:0]        X_DRIVE_O,
  output logic      [NUM_LINES-1:0]        Y_CAPTURE_O,
  output logic                             CS_RESET_O,
  output logic                             ADC_RAMP_O,
  input  wire logic [NUM_LINES-1:0]        Y_CMP_I,
  // Result stream
  output logic                             RES_VALID_O,
  output logic      [KEY_W-1:0]            RES_KEY_O,
  output logic      [CNT_W-1:0]            RES_DATA_O,
  output logic                             SCAN_DONE_O,
  output logic      [LINE_W-1:0]           ACTIVE_LINE_O
);

  // ==========================================================
  // Declarations
  scan_state_t           state_r;
  scan_state_t           state_nxt;
  logic [LINE_W-1:0]     line_r;
  logic [LINE_W-1:0]     line_nxt;
  logic [BL_W-1:0]       pulse_r;
  logic [BL_W-1:0]       pulse_nxt;
  logic [CNT_W-1:0]      tmr_r;
  logic [CNT_W-1:0]      tmr_nxt;
  logic [LINE_W-1:0]     rpt_r;
  logic [LINE_W-1:0]     rpt_nxt;
  logic                  first_r;
  logic                  first_nxt;
  logic [NUM_LINES-1:0]  drive_r;
  logic [NUM_LINES-1:0]  drive_nxt;
  logic                  done_r;
  logic                  done_nxt;
  logic                  res_valid_r;
  logic                  res_valid_nxt;
  logic [KEY_W-1:0]      res_key_r;
  logic [KEY_W-1:0]      res_key_nxt;
  logic [CNT_W-1:0]      res_data_r;
  logic [CNT_W-1:0]      res_data_nxt;

  logic [NUM_LINES-1:0]  cmp_s1_r;
  logic [NUM_LINES-1:0]  cmp_s2_r;

  logic [NUM_KEYS-1:0]   key_en;
  logic [NUM_LINES-1:0]  line_has_key;
  logic                  any_key;
  logic [LINE_W-1:0]     lowest_line;
  logic [LINE_W-1:0]     line_fwd;
  logic                  found_fwd;
  logic [NUM_LINES-1:0]  rx_en;
  logic [BL_W-1:0]       rx_bl [NUM_LINES];
  logic [BL_W-1:0]       burst_max;
  logic [NUM_LINES-1:0]  chan_done;
  logic [CNT_W-1:0]      chan_val [NUM_LINES];
  logic                  all_done;
  logic                  ch_clr;
  logic                  ch_win;
  logic                  ch_conv;

  // ==========================================================
  // Comparator synchroniser
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cmp_s1_r <= '0;
      cmp_s2_r <= '0;
    end else begin
      cmp_s1_r <= Y_CMP_I;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  // ==========================================================
  // Key enables and line selection
  always_comb begin
    key_en       = '0;
    line_has_key = '0;
    lowest_line  = '0;
    line_fwd     = '0;
    found_fwd    = 1'b0;
    for (int k = 0; k < NUM_KEYS; k++) begin
      key_en[k] = |DET_INT_LIMIT_I[k*DIL_W +: DIL_W];
    end
    for (int x = 0; x < NUM_LINES; x++) begin
      for (int y = 0; y < NUM_LINES; y++) begin
        if (key_en[y*NUM_LINES + x]) begin
          line_has_key[x] = 1'b1;
        end
      end
    end
    // Downward walk leaves the lowest qualifying index
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (line_has_key[i]) begin
        lowest_line = LINE_W'(i);
      end
      if (line_has_key[i] && (first_r || (i > int'(line_r)))) begin
        line_fwd  = LINE_W'(i);
        found_fwd = 1'b1;
      end
    end
  end

  assign any_key = |line_has_key;

  // Per receive line settings of the current drive line
  always_comb begin
    rx_en     = '0;
    burst_max = '0;
    for (int y = 0; y < NUM_LINES; y++) begin
      rx_en[y] = key_en[y*NUM_LINES + int'(line_r)];
      rx_bl[y] = BURST_LEN_I[(y*NUM_LINES + int'(line_r))*BL_W +: BL_W];
      if (rx_en[y] && (rx_bl[y] > burst_max)) begin
        burst_max = rx_bl[y];
      end
    end
  end

  assign all_done = &(chan_done | ~rx_en);

  // ==========================================================
  // Receive channels
  assign ch_clr  = (state_r == ST_CSRST);
  assign ch_win  = (state_r == ST_HI);
  assign ch_conv = (state_r == ST_CONV);

  generate
    for (genvar g = 0; g < NUM_LINES; g++) begin : g_rx
      rx_channel u_rx (
        .clk_i       (CORE_CLK_I),
        .rst_i       (SYS_RST_I),
        .clr_i       (ch_clr),
        .en_i        (rx_en[g]),
        .win_i       (ch_win),
        .pulse_i     (pulse_r),
        .burst_len_i (rx_bl[g]),
        .conv_i      (ch_conv),
        .time_i      (tmr_r),
        .cmp_i       (cmp_s2_r[g]),
        .cap_o       (Y_CAPTURE_O[g]),
        .val_o       (chan_val[g]),
        .done_o      (chan_done[g])
      );
    end
  endgenerate

  // ==========================================================
  // Scan sequencer
  always_comb begin
    state_nxt     = state_r;
    line_nxt      = line_r;
    pulse_nxt     = pulse_r;
    tmr_nxt       = tmr_r;
    rpt_nxt       = rpt_r;
    first_nxt     = first_r;
    done_nxt      = 1'b0;
    res_valid_nxt = 1'b0;
    res_key_nxt   = res_key_r;
    res_data_nxt  = res_data_r;
    case (state_r)
      ST_IDLE: begin
        first_nxt = 1'b1;
        if (SCAN_EN_I && any_key) begin
          state_nxt = ST_FIND;
        end
      end
      ST_FIND: begin
        if (!SCAN_EN_I || !any_key) begin
          state_nxt = ST_IDLE;
        end else begin
          // Skipped lines cost nothing; wrap to the lowest live line
          line_nxt  = found_fwd ? line_fwd : lowest_line;
          done_nxt  = !found_fwd;
          first_nxt = 1'b0;
          tmr_nxt   = '0;
          state_nxt = ST_CSRST;
        end
      end
      ST_CSRST: begin
        tmr_nxt = tmr_r + CNT_W'(1);
        if (tmr_r == CNT_W'(CS_RESET_CYC - 1)) begin
          tmr_nxt   = '0;
          pulse_nxt = '0;
          state_nxt = (burst_max == '0) ? ST_CONV : ST_HI;
        end
      end
      ST_HI: begin
        tmr_nxt = tmr_r + CNT_W'(1);
        if (tmr_r == CNT_W'(DWELL_CYC - 1)) begin
          tmr_nxt   = '0;
          state_nxt = ST_LO;
        end
      end
      ST_LO: begin
        tmr_nxt = tmr_r + CNT_W'(1);
        if (tmr_r == CNT_W'(PULSE_LO_CYC - 1)) begin
          tmr_nxt   = '0;
          pulse_nxt = pulse_r + BL_W'(1);
          // Slot length set by this line's settings only
          if ((pulse_r + BL_W'(1)) == burst_max) begin
            state_nxt = ST_CONV;
          end else begin
            state_nxt = ST_HI;
          end
        end
      end
      ST_CONV: begin
        tmr_nxt = tmr_r + CNT_W'(1);
        // Timeout keeps a stuck comparator from stalling the scan
        if (all_done || (tmr_r == CNT_W'(ADC_MAX_CYC - 1))) begin
          tmr_nxt   = '0;
          rpt_nxt   = '0;
          state_nxt = ST_REPORT;
        end
      end
      ST_REPORT: begin
        res_valid_nxt = rx_en[rpt_r];
        res_key_nxt   = {rpt_r, line_r};
        res_data_nxt  = chan_val[rpt_r];
        rpt_nxt       = rpt_r + LINE_W'(1);
        if (rpt_r == LINE_W'(NUM_LINES - 1)) begin
          state_nxt = ST_FIND;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    drive_nxt = (state_nxt == ST_HI) ?
                (NUM_LINES'(1) << line_nxt) : '0;
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_r     <= ST_IDLE;
      line_r      <= '0;
      pulse_r     <= '0;
      tmr_r       <= '0;
      rpt_r       <= '0;
      first_r     <= 1'b1;
      drive_r     <= '0;
      done_r      <= 1'b0;
      res_valid_r <= 1'b0;
      res_key_r   <= '0;
      res_data_r  <= '0;
    end else begin
      state_r     <= state_nxt;
      line_r      <= line_nxt;
      pulse_r     <= pulse_nxt;
      tmr_r       <= tmr_nxt;
      rpt_r       <= rpt_nxt;
      first_r     <= first_nxt;
      drive_r     <= drive_nxt;
      done_r      <= done_nxt;
      res_valid_r <= res_valid_nxt;
      res_key_r   <= res_key_nxt;
      res_data_r  <= res_data_nxt;
    end
  end

  assign X_DRIVE_O     = drive_r;
  assign CS_RESET_O    = (state_r == ST_CSRST);
  assign ADC_RAMP_O    = (state_r == ST_CONV);
  assign RES_VALID_O   = res_valid_r;
  assign RES_KEY_O     = res_key_r;
  assign RES_DATA_O    = res_data_r;
  assign SCAN_DONE_O   = done_r;
  assign ACTIVE_LINE_O = line_r;

  // ==========================================================
  // Checks
  AST_START_ZERO: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (state_r == ST_FIND && first_r && SCAN_EN_I && line_has_key[0])
    |=> (line_r == '0))
    else $error("scan did not start at drive line zero");

  AST_ASCEND: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (state_r == ST_FIND && SCAN_EN_I && found_fwd && !first_r)
    |=> (line_r > $past(line_r)))
    else $error("drive line did not ascend");

  AST_ONE_LINE: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (X_DRIVE_O != '0) |-> ($onehot(X_DRIVE_O) && X_DRIVE_O[line_r]
                           && state_r == ST_HI))
    else $error("drive not the single current line");

  AST_LINE_HOLD: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $changed(line_r) |-> ($past(state_r) == ST_FIND))
    else $error("drive line changed inside a burst");

  AST_REPORT_RUN: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(state_r == ST_REPORT) |->
    ($past(state_r) == ST_CONV) and
    ((state_r == ST_REPORT)[*8] ##1 (state_r == ST_FIND)))
    else $error("report pass not eight cycles after conversion");

  AST_SKIP_DISABLED: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    RES_VALID_O |-> key_en[RES_KEY_O])
    else $error("result reported for a disabled key");

  AST_LIVE_LINE: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (state_r == ST_CSRST) |-> line_has_key[line_r])
    else $error("timeslot given to a line with no enabled key");

  AST_WRAP_LOWEST: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (state_r == ST_FIND && SCAN_EN_I && any_key && !found_fwd)
    |=> (line_r == $past(lowest_line)) && SCAN_DONE_O)
    else $error("scan did not restart at lowest enabled line");

  COV_SKIP_LINE: cover property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $changed(line_r) && (line_r > $past(line_r) + LINE_W'(1)));

  COV_WRAP: cover property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    SCAN_DONE_O);

  COV_RESULT: cover property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    RES_VALID_O && (RES_DATA_O != NO_TRIP_VAL));

endmodule // touch_matrix_scan_sequencer

// *** verilog/touch_scan_pkg.sv ***
package touch_scan_pkg;

  // ==========================================================
  // Matrix geometry
  localparam int NUM_LINES = 8;
  localparam int NUM_KEYS  = 64;
  localparam int LINE_W    = 3;
  localparam int KEY_W     = 6;
  localparam int BL_W      = 8;
  localparam int DIL_W     = 8;
  localparam int CNT_W     = 12;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ     = 100;
  localparam int DWELL_NS    = 125;
  localparam int DWELL_CYC   = (DWELL_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_LO_NS = 500;
  localparam int PULSE_LO_CYC = (PULSE_LO_NS * CLK_MHZ + 999) / 1000;
  localparam int CS_RESET_NS = 1000;
  localparam int CS_RESET_CYC = (CS_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int ADC_MAX_NS  = 40000;
  localparam int ADC_MAX_CYC = (ADC_MAX_NS * CLK_MHZ) / 1000;

  // ==========================================================
  // Reset values
  localparam logic [CNT_W-1:0] NO_TRIP_VAL = 12'hfff;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIND,
    ST_CSRST,
    ST_HI,
    ST_LO,
    ST_CONV,
    ST_REPORT
  } scan_state_t;

endpackage
